// ===== src/opaddr_core.sv
/*
 * Operand addressing unit of a small 8-bit CPU core. Takes a decoded
 * opcode byte and an operand byte, reaches RAM or register space, and
 * updates the internal result, index, stack and condition registers.
 * Assumes a memory whose read data stands before the edge ending the strobe.
 */
// Overview of operation
// RL1: Source immediate uses the operand byte itself as source value.
// RL2: Source immediate writes result to opcode-selected internal register.
// RL3: Immediate arithmetic second operand is that same selected register.
// RL4: Source direct reads source from operand-addressed RAM or reg space.
// RL5: Source indexed address is operand plus index register.
// RL6: Direct/indexed source write result or index register, also 2nd operand.
// RL7: Destination direct writes result/index value to operand-addressed place.
// RL8: Destination arithmetic reads second operand from that same location.
// RL9: Every such instruction is exactly opcode byte then operand byte.
// RL10: Destination store leaves the result register unchanged.
// RL11: Every access carries a RAM/register space select.
`timescale 1ns/1ps
module opaddr_core
    import opaddr_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic             clk_in,        // 10 MHz clock
    input  wire logic             reset_in,      // Sync reset, high
    input  wire logic             byte_vld_in,   // Instruction byte valid
    input  wire logic [WIDTH-1:0] byte_in,       // Instruction byte
    input  wire addr_mode_t       mode_in,       // Mode, with opcode
    input  wire reg_sel_t         sel_in,        // Register select
    input  wire alu_op_t          op_in,         // Operation
    input  wire logic             space_in,      // 1 = register space
    input  wire logic [WIDTH-1:0] mem_rdata_in,  // Read data
    output logic                  byte_rdy_out,  // Byte accepted
    output logic                  mem_rd_out,    // Read strobe
    output logic                  mem_wr_out,    // Write strobe
    output logic                  mem_space_out, // Space select
    output logic      [WIDTH-1:0] mem_addr_out,  // Address
    output logic      [WIDTH-1:0] mem_wdata_out, // Write data
    output logic                  done_out,      // Instruction done
    output logic      [WIDTH-1:0] result_out,    // result_reg
    output logic      [WIDTH-1:0] index_out,     // index_reg
    output logic      [WIDTH-1:0] stack_out,     // stack_pointer
    output logic      [WIDTH-1:0] cond_out       // cond_bits_reg
);
    initial begin
        if (WIDTH != DATA_W) $error("WIDTH must equal DATA_W");
    end

    typedef enum logic [2:0] {
        ST_OPCODE  = 3'h0,
        ST_OPERAND = 3'h1,
        ST_READ    = 3'h2,
        ST_EXEC    = 3'h3,
        ST_WRITE   = 3'h4
    } state_t;

    typedef struct packed {
        state_t           state;
        addr_mode_t       mode;
        reg_sel_t         sel;
        alu_op_t          op;
        logic             space;
        logic [WIDTH-1:0] operand;
        logic [WIDTH-1:0] addr;
        logic [WIDTH-1:0] rdata;
        logic [WIDTH-1:0] result;
        logic [WIDTH-1:0] index;
        logic [WIDTH-1:0] stack;
        logic [WIDTH-1:0] cond;
        logic             rd;
        logic             wr;
        logic [WIDTH-1:0] wdata;
        logic             done;
    } core_t;

    core_t cur_reg;
    core_t cur_next;

    logic [WIDTH-1:0] src_val;
    logic [WIDTH-1:0] sec_val;
    logic [WIDTH-1:0] alu_res;
    logic [WIDTH-1:0] sel_val;

    // Value of the opcode-selected internal register
    always_comb begin
        unique case (cur_reg.sel)
            SEL_RESULT: sel_val = cur_reg.result;
            SEL_INDEX:  sel_val = cur_reg.index;
            SEL_STACK:  sel_val = cur_reg.stack;
            SEL_COND:   sel_val = cur_reg.cond;
        endcase
    end

    // Operand routing per mode
    always_comb begin
        unique case (cur_reg.mode)
            MODE_SRC_IMM: begin
                src_val = cur_reg.operand; // RL1
                sec_val = sel_val; // RL3
            end
            MODE_DST_DIR: begin
                src_val = sel_val; // RL7
                sec_val = cur_reg.rdata; // RL8
            end
            default: begin
                src_val = cur_reg.rdata; // RL4
                sec_val = sel_val; // RL6
            end
        endcase
    end

    opaddr_alu #(
        .WIDTH (WIDTH)
    ) u_alu (
        .op_in   (cur_reg.op),
        .src_in  (src_val),
        .sec_in  (sec_val),
        .res_out (alu_res)
    );

    // Next-state logic
    always_comb begin
        cur_next = cur_reg;
        cur_next.rd = 1'h0;
        cur_next.wr = 1'h0;
        cur_next.done = 1'h0;
        unique case (cur_reg.state)
            ST_OPCODE: begin
                if (byte_vld_in) begin
                    cur_next.mode = mode_in;
                    // Memory modes only reach result or index
                    cur_next.sel = (mode_in == MODE_SRC_IMM) ? sel_in
                        : reg_sel_t'({1'h0, sel_in[0]});
                    cur_next.op = op_in;
                    cur_next.space = space_in;
                    cur_next.state = ST_OPERAND; // RL9
                end
            end
            ST_OPERAND: begin
                if (byte_vld_in) begin
                    cur_next.operand = byte_in;
                    // Indexed adds index register, wraps in 8 bits
                    cur_next.addr = (cur_reg.mode == MODE_SRC_IDX)
                        ? WIDTH'(byte_in + cur_reg.index) // RL5
                        : byte_in;
                    if (cur_reg.mode == MODE_SRC_IMM) begin
                        cur_next.state = ST_EXEC;
                    end else if (cur_reg.mode == MODE_DST_DIR
                                 && cur_reg.op == OP_MOV) begin
                        // Plain store needs no read of the target
                        cur_next.state = ST_EXEC;
                    end else begin
                        cur_next.rd = 1'h1;
                        cur_next.state = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // Sampled while the read strobe stands, no extra wait state
                cur_next.rdata = mem_rdata_in;
                cur_next.state = ST_EXEC;
            end
            ST_EXEC: begin
                if (cur_reg.mode == MODE_DST_DIR) begin
                    cur_next.wr = 1'h1; // RL7
                    cur_next.wdata = alu_res; // RL10
                    cur_next.state = ST_WRITE;
                end else begin
                    unique case (cur_reg.sel)
                        SEL_RESULT: cur_next.result = alu_res; // RL2
                        SEL_INDEX:  cur_next.index = alu_res; // RL6
                        SEL_STACK:  cur_next.stack = alu_res; // RL2
                        SEL_COND:   cur_next.cond = alu_res; // RL2
                    endcase
                    cur_next.done = 1'h1;
                    cur_next.state = ST_OPCODE;
                end
            end
            ST_WRITE: begin
                cur_next.done = 1'h1;
                cur_next.state = ST_OPCODE;
            end
            default: cur_next.state = ST_OPCODE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cur_reg <= '0;
            cur_reg.state <= ST_OPCODE;
            cur_reg.result <= RESULT_RST;
            cur_reg.index <= INDEX_RST;
            cur_reg.stack <= STACK_RST;
            cur_reg.cond <= COND_RST;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Byte ready only while waiting for instruction bytes
    assign byte_rdy_out = (cur_reg.state == ST_OPCODE)
                       || (cur_reg.state == ST_OPERAND);
    assign mem_rd_out    = cur_reg.rd;
    assign mem_wr_out    = cur_reg.wr;
    assign mem_space_out = cur_reg.space; // RL11
    assign mem_addr_out  = cur_reg.addr;
    assign mem_wdata_out = cur_reg.wdata;
    assign done_out      = cur_reg.done;
    assign result_out    = cur_reg.result;
    assign index_out     = cur_reg.index;
    assign stack_out     = cur_reg.stack;
    assign cond_out      = cur_reg.cond;

    // Immediate source lands in the selected register
    AST_IMM_MOV: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_EXEC && cur_reg.mode == MODE_SRC_IMM
         && cur_reg.op == OP_MOV && cur_reg.sel == SEL_INDEX)
        |=> index_out == $past(cur_reg.operand)) // RL1
        else $error("immediate move did not load operand");

    AST_IMM_ADD: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_EXEC && cur_reg.mode == MODE_SRC_IMM
         && cur_reg.op == OP_ADD && cur_reg.sel == SEL_RESULT)
        |=> result_out
            == WIDTH'($past(cur_reg.result) + $past(cur_reg.operand)))
        // RL3
        else $error("immediate add used wrong second operand");

    AST_IMM_DEST: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_EXEC && cur_reg.mode == MODE_SRC_IMM
         && cur_reg.sel == SEL_COND) |=> $stable(index_out)
         && $stable(result_out) && $stable(stack_out)) // RL2
        else $error("immediate result reached wrong register");

    AST_DIR_READ: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPERAND && byte_vld_in
         && cur_reg.mode == MODE_SRC_DIR)
        |=> mem_rd_out && mem_addr_out == $past(byte_in)) // RL4
        else $error("direct read address wrong");

    AST_IDX_ADDR: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPERAND && byte_vld_in
         && cur_reg.mode == MODE_SRC_IDX)
        |=> mem_rd_out
        && mem_addr_out == WIDTH'($past(byte_in) + $past(index_out))) // RL5
        else $error("indexed address wrong");

    AST_SRC_MEM: assert property (@(posedge clk_in) disable iff (reset_in)
        (mem_rd_out && cur_reg.mode != MODE_DST_DIR && cur_reg.op == OP_MOV
         && cur_reg.sel == SEL_INDEX)
        ##1 1'h1 ##1 1'h1 |-> index_out == $past(mem_rdata_in, 2)) // RL6
        else $error("memory source not loaded");

    AST_DST_WR: assert property (@(posedge clk_in) disable iff (reset_in)
        (mem_rd_out && cur_reg.mode == MODE_DST_DIR && cur_reg.op == OP_ADD)
        |-> ##2 mem_wr_out && mem_addr_out == $past(mem_addr_out, 2)
        && mem_wdata_out == WIDTH'($past(mem_rdata_in, 2) + $past(sel_val, 1)))
        // RL8
        else $error("destination arithmetic wrong");

    AST_DST_KEEP: assert property (@(posedge clk_in) disable iff (reset_in)
        mem_wr_out |-> $stable(result_out) && $stable(index_out)) // RL10
        else $error("store changed an internal register");

    AST_TWO_BYTES: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPCODE && byte_vld_in)
        |=> cur_reg.state == ST_OPERAND && byte_rdy_out) // RL9
        else $error("opcode not followed by operand byte");

    AST_SPACE: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPCODE && byte_vld_in)
        |=> mem_space_out == $past(space_in)) // RL11
        else $error("space select not held");

    AST_DST_MOV: assert property (@(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_EXEC && cur_reg.mode == MODE_DST_DIR
         && cur_reg.op == OP_MOV)
        |=> mem_wr_out && mem_wdata_out == $past(sel_val)) // RL7
        else $error("destination store data wrong");

    // Immediate operand is a value, never an address
    AST_IMM_NOREAD: assert property ( // RL1
        @(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPERAND && byte_vld_in
         && cur_reg.mode == MODE_SRC_IMM)
        |=> !mem_rd_out ##1 !mem_wr_out)
        else $error("immediate operand used as address");

    // Memory sources only reach the result or index register
    AST_SRC_KEEP: assert property ( // RL6
        @(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_EXEC && (cur_reg.mode == MODE_SRC_DIR
         || cur_reg.mode == MODE_SRC_IDX))
        |=> $stable(stack_out) && $stable(cond_out))
        else $error("memory source reached wrong register");

    // Destination address is the operand byte itself
    AST_DST_ADDR: assert property ( // RL7
        @(posedge clk_in) disable iff (reset_in)
        (cur_reg.state == ST_OPERAND && byte_vld_in
         && cur_reg.mode == MODE_DST_DIR)
        |=> mem_addr_out == $past(byte_in) && !mem_wr_out)
        else $error("destination address wrong");
endmodule // opaddr_core

// ===== src/opaddr_pkg.sv
/*
 * Shared constants for the operand addressing block: widths, mode codes,
 * register selects, ALU operations and reset values.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package opaddr_pkg;
    localparam int DATA_W = 8;

    // Addressing modes handled by this block
    typedef enum logic [1:0] {
        MODE_SRC_IMM = 2'h0,
        MODE_SRC_DIR = 2'h1,
        MODE_SRC_IDX = 2'h2,
        MODE_DST_DIR = 2'h3
    } addr_mode_t;

    // Internal register selects
    typedef enum logic [1:0] {
        SEL_RESULT = 2'h0,
        SEL_INDEX  = 2'h1,
        SEL_STACK  = 2'h2,
        SEL_COND   = 2'h3
    } reg_sel_t;

    // Operations
    typedef enum logic [2:0] {
        OP_MOV = 3'h0,
        OP_ADD = 3'h1,
        OP_SUB = 3'h2,
        OP_AND = 3'h3,
        OP_OR  = 3'h4,
        OP_XOR = 3'h5
    } alu_op_t;

    // Address space select values
    localparam logic SPACE_RAM = 1'h0;
    localparam logic SPACE_REG = 1'h1;

    // Reset values of the internal registers
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] INDEX_RST  = 8'h00;
    localparam logic [7:0] STACK_RST  = 8'h00;
    localparam logic [7:0] COND_RST   = 8'h02;
endpackage

// ===== src/opaddr_alu.sv
/*
 * Combinational operation unit: forms a result from the source value and
 * the second operand. Pure logic, no state.
 */
`timescale 1ns/1ps
module opaddr_alu
    import opaddr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire alu_op_t          op_in,   // Operation
    input  wire logic [WIDTH-1:0] src_in,  // Source value
    input  wire logic [WIDTH-1:0] sec_in,  // Second operand
    output logic      [WIDTH-1:0] res_out  // Result
);
    initial begin
        if (WIDTH < 1) $error("WIDTH must be positive");
    end

    // Move passes source; others combine both operands
    always_comb begin
        unique case (op_in)
            OP_MOV:  res_out = src_in;
            OP_ADD:  res_out = WIDTH'(sec_in + src_in);
            OP_SUB:  res_out = WIDTH'(sec_in - src_in);
            OP_AND:  res_out = sec_in & src_in;
            OP_OR:   res_out = sec_in | src_in;
            OP_XOR:  res_out = sec_in ^ src_in;
            default: res_out = src_in;
        endcase
    end
endmodule // opaddr_alu

// ===== test/opaddr_mem_model.sv
/*
 * Behavioural RAM and register space seen by the operand addressing core.
 * Assumes one clock; read data shows while the read strobe stands.
 */
`timescale 1ns/1ps
module opaddr_mem_model
    import opaddr_pkg::*;
(
    input  wire logic              clk_in,    // Core clock
    input  wire logic              rd_in,     // Read strobe
    input  wire logic              wr_in,     // Write strobe
    input  wire logic              space_in,  // 1 = register space
    input  wire logic [DATA_W-1:0] addr_in,   // Address
    input  wire logic [DATA_W-1:0] wdata_in,  // Write data
    output logic      [DATA_W-1:0] rdata_out  // Read data
);
    logic [DATA_W-1:0] mem [2][256];

    // Outside a read the inverse shows, so a late sample sees wrong data
    assign rdata_out = rd_in ? mem[space_in][addr_in]
                             : ~mem[space_in][addr_in];

    // Writes land on the edge that sees the strobe
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[space_in][addr_in] <= wdata_in;
        end
    end
endmodule // opaddr_mem_model

// ===== test/tb_top.sv
/*
 * Self-checking bench for the operand addressing core with memory model.
 * Assumes bytes are taken on rising edges while byte_rdy_out is high.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("FAIL t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    import opaddr_pkg::*;
    logic clk_in, reset_in, byte_vld_in, space_in;
    logic [7:0] byte_in, mem_rdata_in, mem_addr_out, mem_wdata_out;
    logic [7:0] result_out, index_out, stack_out, cond_out;
    logic byte_rdy_out, mem_rd_out, mem_wr_out, mem_space_out, done_out;
    addr_mode_t mode_in;
    reg_sel_t   sel_in;
    alu_op_t    op_in;
    logic [7:0] sh [2][256];
    logic [7:0] r [4];
    logic [8:0] q_rd [$];
    logic [16:0] q_wr [$];
    logic [31:0] q_dn [$];
    int fails = 0, n_checks = 0;

    opaddr_core i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .byte_vld_in(byte_vld_in), .byte_in(byte_in), .mode_in(mode_in),
        .sel_in(sel_in), .op_in(op_in), .space_in(space_in),
        .mem_rdata_in(mem_rdata_in), .byte_rdy_out(byte_rdy_out),
        .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_space_out(mem_space_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .done_out(done_out),
        .result_out(result_out), .index_out(index_out),
        .stack_out(stack_out), .cond_out(cond_out));
    opaddr_mem_model i_mem (.clk_in(clk_in), .rd_in(mem_rd_out),
        .wr_in(mem_wr_out), .space_in(mem_space_out),
        .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
        .rdata_out(mem_rdata_in));

    always #50 clk_in = ~clk_in;

    function automatic logic [7:0] alu_f(int o, logic [7:0] a, logic [7:0] b);
        case (o)
            1: return b + a;
            2: return b - a;
            3: return b & a;
            4: return b | a;
            5: return b ^ a;
            default: return a;
        endcase
    endfunction

    task automatic complete_run();
        $display("COUNTS checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Bounded wait for the byte to be taken; returns just after the edge
    task automatic wait_take();
        int k;
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (byte_rdy_out !== 1'b1 && k < 50);
        if (byte_rdy_out !== 1'b1) begin
            fails++;
            complete_run();
        end
        @(posedge clk_in);
    endtask

    // Bounded wait until every noted result has been seen
    task automatic wait_idle();
        int k;
        for (k = 0; k < 60 && q_dn.size() + q_wr.size() + q_rd.size() > 0; k++)
            @(negedge clk_in);
        if (k == 60) begin
            fails++;
            complete_run();
        end
        @(posedge clk_in);
    endtask

    task automatic do_reset();
        #1 reset_in = 1'b1;
        repeat (16) @(posedge clk_in);
        #1 reset_in = 1'b0;
        r = '{RESULT_RST, INDEX_RST, STACK_RST, COND_RST};
        @(negedge clk_in);
        `CHK({result_out, index_out, stack_out, cond_out}, {r[0], r[1], r[2], r[3]})
        `CHK({byte_rdy_out, mem_rd_out, mem_wr_out, done_out}, 4'h8)
        @(posedge clk_in);
    endtask

    // Note expectations, then send opcode and operand bytes
    task automatic run(int m, int s, int o, logic p, logic [7:0] v, bit wt);
        logic [7:0] a;
        int d;
        d = (m == 0) ? s : s % 2;
        a = (m == 2) ? v + r[1] : v;
        if (m == 0) r[d] = alu_f(o, v, r[d]);
        else if (m < 3) begin
            q_rd.push_back({p, a});
            r[d] = alu_f(o, sh[p][a], r[d]);
        end else begin
            if (o != 0) q_rd.push_back({p, a});
            sh[p][a] = alu_f(o, r[d], sh[p][a]);
            q_wr.push_back({p, a, sh[p][a]});
        end
        q_dn.push_back({r[0], r[1], r[2], r[3]});
        #1 mode_in = addr_mode_t'(m);
        sel_in = reg_sel_t'(s);
        op_in = alu_op_t'(o);
        space_in = p;
        byte_vld_in = 1'b1;
        byte_in = $urandom;
        wait_take();
        // Operand must stand before the next edge, or the opcode byte is taken as operand
        #1 byte_in = v;
        @(negedge clk_in);
        `CHK(byte_rdy_out, 1'b1)
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK(byte_rdy_out, 1'b0)
        @(posedge clk_in);
        if (wt) begin
            #1 byte_vld_in = 1'b0;
            wait_idle();
        end
    endtask

    // Result watcher: takes the oldest note whenever a strobe appears
    always @(negedge clk_in) begin
        if (!reset_in && mem_rd_out === 1'b1) begin
            if (q_rd.size() == 0) q_rd.push_back(9'h1FF ^ {mem_space_out, mem_addr_out});
            `CHK({mem_space_out, mem_addr_out}, q_rd.pop_front())
        end
        if (!reset_in && mem_wr_out === 1'b1) begin
            if (q_wr.size() == 0) q_wr.push_back(17'h1FFFF);
            `CHK({mem_space_out, mem_addr_out, mem_wdata_out}, q_wr.pop_front())
        end
        if (!reset_in && done_out === 1'b1) begin
            if (q_dn.size() == 0) q_dn.push_back(32'hFFFFFFFF);
            `CHK({result_out, index_out, stack_out, cond_out}, q_dn.pop_front())
        end
    end

    initial begin
        int m, o, s, p, k;
        logic [7:0] a;
        clk_in = 1'b0;
        reset_in = 1'b1;
        byte_vld_in = 1'b0;
        byte_in = 8'h00;
        mode_in = MODE_SRC_IMM;
        sel_in = SEL_RESULT;
        op_in = OP_MOV;
        space_in = 1'b0;
        void'($urandom(32'hB72C));
        for (k = 0; k < 512; k++) begin
            sh[k / 256][k % 256] = $urandom;
            i_mem.mem[k / 256][k % 256] = sh[k / 256][k % 256];
        end
        do_reset();
        $display("TEST reset done");
        for (o = 0; o < 6; o++)
            for (s = 0; s < 4; s++) run(0, s, o, 1'b0, $urandom, 1);
        $display("TEST immediate done");
        run(0, 1, 0, 1'b0, 8'hF0, 1);
        for (m = 1; m < 3; m++)
            for (k = 0; k < 24; k++)
                run(m, k % 2, k / 4, k[1], $urandom_range(8'hFF, 8'h10), 1);
        $display("TEST direct and indexed done");
        for (k = 0; k < 12; k++) begin
            a = $urandom;
            run(3, k % 2, k / 2, k[0], a, 1);
            run(1, 0, 0, k[0], a, 1);
        end
        $display("TEST destination done");
        for (k = 0; k < 60; k++)
            run($urandom_range(3), $urandom_range(3), $urandom_range(5),
                $urandom_range(1), $urandom, 0);
        #1 byte_vld_in = 1'b0;
        wait_idle();
        $display("TEST back to back done");
        do_reset();
        run(1, 0, 1, 1'b1, 8'h08, 1);
        $display("TEST second reset done");
        complete_run();
    end
endmodule // tb_top
